// >>> asx_consts.svh
// Constants for the add and shift execute unit
`ifndef ASX_CONSTS_SVH
`define ASX_CONSTS_SVH
`define ASX_LIT_MSB 5
`define ASX_NIB_BIT 4
`define ASX_CARRY_BIT 8
`define ASX_SIGN_BIT 7
`define ASX_DEST_FILE 1'b1
`define ASX_ACC_RESET 8'h00
`define ASX_PTR_RESET 16'h0000
`define ASX_BYTE_ZERO 8'h00
`endif

// >>> asx_pkg.sv
// Types for the add and shift execute unit
package asx_pkg;
   typedef enum logic [7:0] {
      ASX_NONE = 8'h01,
      ASX_ADD_PTR = 8'h02,
      ASX_ADD_IMM = 8'h04,
      ASX_ADD_FILE = 8'h08,
      ASX_ADD_FILE_C = 8'h10,
      ASX_AND_IMM = 8'h20,
      ASX_AND_FILE = 8'h40,
      ASX_ASR = 8'h80
   } asx_op_t;
endpackage

// >>> asx_exec.sv
// Execute datapath for add, and and arithmetic shift operations
// Function
// - Pointer add: sign-extended 6-bit literal into pointer
// - Pointer sum wraps 16 bits, flags unchanged
// - Add immediate to accumulator, update C, DC, Z
// - Add file to accumulator, routed by destination bit
// - Add file plus carry, routed, update C, DC, Z
// - AND immediate into accumulator, only Z updated
// - AND file, routed by destination, only Z
// - Shift right: bits 7..1 down, bit0 to carry
// - Shift keeps sign bit, updates C Z only
`timescale 1ns/10ps
`include "asx_consts.svh"
module asx_exec (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire asx_pkg::asx_op_t op,
   input wire logic [7:0] imm,
   input wire logic [5:0] ptr_lit,
   input wire logic ptr_sel,
   input wire logic dest_sel,
   input wire logic [7:0] file_rdata,
   output logic [7:0] acc,
   output logic [15:0] indirect_pointer0,
   output logic [15:0] indirect_pointer1,
   output logic carry_flag,
   output logic half_carry_flag,
   output logic zero_flag,
   output logic file_we,
   output logic [7:0] file_wdata
);
   // Adder shared by all three add operations
   function automatic logic [8:0] add8(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic ci);
      add8 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
   endfunction

   // Carry out of bit 3 for the half-carry flag
   function automatic logic nib_carry(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic ci);
      logic [4:0] s;
      s = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      nib_carry = s[`ASX_NIB_BIT];
   endfunction

   // Operation decode
   wire is_ptr = (op == asx_pkg::ASX_ADD_PTR);
   wire is_addi = (op == asx_pkg::ASX_ADD_IMM);
   wire is_addf = (op == asx_pkg::ASX_ADD_FILE);
   wire is_addc = (op == asx_pkg::ASX_ADD_FILE_C);
   wire is_andi = (op == asx_pkg::ASX_AND_IMM);
   wire is_andf = (op == asx_pkg::ASX_AND_FILE);
   wire is_asr = (op == asx_pkg::ASX_ASR);
   wire is_add = is_addi | is_addf | is_addc;
   wire is_routed = is_addf | is_addc | is_andf | is_asr;

   // Operand selection; immediate forms take the literal
   wire [7:0] opnd_b = (is_addi | is_andi) ? imm : file_rdata;
   wire add_ci = is_addc & carry_flag;
   wire [8:0] add_sum = add8(acc, opnd_b, add_ci);
   wire add_dc = nib_carry(acc, opnd_b, add_ci);
   wire [7:0] and_res = acc & opnd_b;
   wire [7:0] asr_res = {file_rdata[`ASX_SIGN_BIT],
                         file_rdata[7:1]};

   // Result select and zero detect
   wire [7:0] result = is_add ? add_sum[7:0] :
                       is_asr ? asr_res : and_res;
   wire res_zero = (result == `ASX_BYTE_ZERO);
   wire to_file = is_routed & (dest_sel == `ASX_DEST_FILE);
   wire writes_acc = (is_add | is_andi | is_andf | is_asr) & ~to_file;

   // Pointer arithmetic truncates to 16 bits, so it wraps by itself
   wire [15:0] ptr_cur = ptr_sel ? indirect_pointer1 : indirect_pointer0;
   wire [15:0] lit_ext = {{10{ptr_lit[`ASX_LIT_MSB]}}, ptr_lit};
   wire [15:0] ptr_sum = ptr_cur + lit_ext;

   // File write-back is a one-cycle strobe with registered data
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         file_we <= 1'b0;
         file_wdata <= `ASX_BYTE_ZERO;
      end
      else
      begin
         file_we <= to_file;
         file_wdata <= result;
      end
   end

   // Accumulator and pointers
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         acc <= `ASX_ACC_RESET;
         indirect_pointer0 <= `ASX_PTR_RESET;
         indirect_pointer1 <= `ASX_PTR_RESET;
      end
      else
      begin
         if (writes_acc)
            acc <= result;
         if (is_ptr && !ptr_sel)
            indirect_pointer0 <= ptr_sum;
         if (is_ptr && ptr_sel)
            indirect_pointer1 <= ptr_sum;
      end
   end

   // Flags; pointer add touches none of them
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         carry_flag <= 1'b0;
         half_carry_flag <= 1'b0;
         zero_flag <= 1'b0;
      end
      else
      begin
         if (is_add)
            carry_flag <= add_sum[`ASX_CARRY_BIT];
         else if (is_asr)
            carry_flag <= file_rdata[0];
         if (is_add)
            half_carry_flag <= add_dc;
         if (is_add | is_andi | is_andf | is_asr)
            zero_flag <= res_zero;
      end
   end

   // Checks beside the datapath
   property p_ptr_wrap;
      @(posedge ref_clk) disable iff (!resetn)
      (is_ptr && !ptr_sel) |=> indirect_pointer0 ==
         $past(indirect_pointer0) +
         {{10{$past(ptr_lit[`ASX_LIT_MSB])}}, $past(ptr_lit)};
   endproperty
   a_ptr_wrap: assert property (p_ptr_wrap)
      else $error("pointer 0 sum wrong");

   property p_ptr_flags;
      @(posedge ref_clk) disable iff (!resetn)
      is_ptr |=> $stable(carry_flag) && $stable(zero_flag)
         && $stable(half_carry_flag);
   endproperty
   a_ptr_flags: assert property (p_ptr_flags)
      else $error("pointer add changed a flag");

   property p_addi;
      @(posedge ref_clk) disable iff (!resetn)
      is_addi |=> {carry_flag, acc} ==
         {1'b0, $past(acc)} + {1'b0, $past(imm)};
   endproperty
   a_addi: assert property (p_addi)
      else $error("add immediate result wrong");

   property p_addf_route;
      @(posedge ref_clk) disable iff (!resetn)
      (is_addf && dest_sel) |=> file_we && $stable(acc) &&
         file_wdata == $past(acc) + $past(file_rdata);
   endproperty
   a_addf_route: assert property (p_addf_route)
      else $error("add file not routed to file");

   property p_addc;
      @(posedge ref_clk) disable iff (!resetn)
      (is_addc && !dest_sel) |=> {carry_flag, acc} ==
         {1'b0, $past(acc)} + {1'b0, $past(file_rdata)}
         + {8'h00, $past(carry_flag)};
   endproperty
   a_addc: assert property (p_addc)
      else $error("add with carry wrong");

   property p_andi;
      @(posedge ref_clk) disable iff (!resetn)
      is_andi |=> acc == ($past(acc) & $past(imm)) &&
         $stable(carry_flag) && !file_we;
   endproperty
   a_andi: assert property (p_andi)
      else $error("and immediate wrong");

   property p_andf;
      @(posedge ref_clk) disable iff (!resetn)
      (is_andf && dest_sel) |=> file_we && $stable(half_carry_flag)
         && zero_flag == (file_wdata == `ASX_BYTE_ZERO);
   endproperty
   a_andf: assert property (p_andf)
      else $error("and file wrong");

   property p_asr;
      @(posedge ref_clk) disable iff (!resetn)
      (is_asr && !dest_sel) |=> acc == {$past(file_rdata[7]),
         $past(file_rdata[7:1])} && carry_flag == $past(file_rdata[0])
         && $stable(half_carry_flag);
   endproperty
   a_asr: assert property (p_asr)
      else $error("shift result wrong");

   property p_ptr1_wrap;
      @(posedge ref_clk) disable iff (!resetn)
      (is_ptr && ptr_sel) |=> $stable(indirect_pointer0) &&
         indirect_pointer1 == $past(indirect_pointer1) +
         {{10{$past(ptr_lit[`ASX_LIT_MSB])}}, $past(ptr_lit)};
   endproperty
   a_ptr1_wrap: assert property (p_ptr1_wrap)
      else $error("pointer 1 sum wrong");

   // Half carry seen as a wrap of the low nibble, not through the adder
   property p_addi_flags;
      @(posedge ref_clk) disable iff (!resetn)
      is_addi |=> zero_flag == (acc == `ASX_BYTE_ZERO) &&
         half_carry_flag == (acc[3:0] < $past(acc[3:0]));
   endproperty
   a_addi_flags: assert property (p_addi_flags)
      else $error("add immediate flags wrong");

   property p_andf_acc;
      @(posedge ref_clk) disable iff (!resetn)
      (is_andf && !dest_sel) |=> !file_we && $stable(carry_flag) &&
         acc == ($past(acc) & $past(file_rdata));
   endproperty
   a_andf_acc: assert property (p_andf_acc)
      else $error("and file to accumulator wrong");

   property p_asr_file;
      @(posedge ref_clk) disable iff (!resetn)
      (is_asr && dest_sel) |=> file_we && $stable(acc) &&
         file_wdata == {$past(file_rdata[`ASX_SIGN_BIT]),
         $past(file_rdata[7:1])};
   endproperty
   a_asr_file: assert property (p_asr_file)
      else $error("shift not routed to file");
endmodule

// >>> asx_exec_tb.sv
// Self-checking testbench for the add and shift execute unit
`timescale 1ns/10ps
module testbench;
   localparam asx_pkg::asx_op_t op_none = asx_pkg::ASX_NONE;
   localparam asx_pkg::asx_op_t op_ptr = asx_pkg::ASX_ADD_PTR;
   localparam asx_pkg::asx_op_t op_addi = asx_pkg::ASX_ADD_IMM;
   localparam asx_pkg::asx_op_t op_addf = asx_pkg::ASX_ADD_FILE;
   localparam asx_pkg::asx_op_t op_addc = asx_pkg::ASX_ADD_FILE_C;
   localparam asx_pkg::asx_op_t op_andi = asx_pkg::ASX_AND_IMM;
   localparam asx_pkg::asx_op_t op_andf = asx_pkg::ASX_AND_FILE;
   localparam asx_pkg::asx_op_t op_asr = asx_pkg::ASX_ASR;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   asx_pkg::asx_op_t op = op_none;
   logic [7:0] imm = 8'h00;
   logic [5:0] ptr_lit = 6'h00;
   logic ptr_sel = 1'b0;
   logic dest_sel = 1'b0;
   logic [7:0] file_rdata = 8'h00;
   logic [7:0] acc, file_wdata;
   logic [15:0] indirect_pointer0, indirect_pointer1;
   logic carry_flag, half_carry_flag, zero_flag, file_we;
   // Reference state, all zero out of reset
   logic [7:0] m_acc = 8'h00;
   logic [15:0] m_p0 = 16'h0000;
   logic [15:0] m_p1 = 16'h0000;
   logic m_c = 1'b0;
   logic m_dc = 1'b0;
   logic m_z = 1'b0;
   int n_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   asx_exec dut_u (.ref_clk(ref_clk), .resetn(resetn), .op(op), .imm(imm),
      .ptr_lit(ptr_lit), .ptr_sel(ptr_sel), .dest_sel(dest_sel),
      .file_rdata(file_rdata), .acc(acc),
      .indirect_pointer0(indirect_pointer0),
      .indirect_pointer1(indirect_pointer1), .carry_flag(carry_flag),
      .half_carry_flag(half_carry_flag), .zero_flag(zero_flag),
      .file_we(file_we), .file_wdata(file_wdata));
   // Free-running 250 MHz clock
   always #2 ref_clk = ~ref_clk;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (n_errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Drive one op, advance the model, compare once the edge has landed
   task automatic step(input asx_pkg::asx_op_t o, input logic [7:0] k,
      input logic [7:0] f, input logic d, input logic [5:0] l);
      logic [8:0] sum;
      logic [4:0] h;
      logic [7:0] x, r;
      logic ci, wr;
      op = o;
      imm = k;
      file_rdata = f;
      dest_sel = d;
      ptr_lit = l;
      ptr_sel = d;
      x = (o == op_addi || o == op_andi) ? k : f;
      ci = (o == op_addc) ? m_c : 1'b0;
      sum = {1'b0, m_acc} + {1'b0, x} + {8'h00, ci};
      h = {1'b0, m_acc[3:0]} + {1'b0, x[3:0]} + {4'h0, ci};
      r = (o == op_asr) ? {f[7], f[7:1]} : (m_acc & x);
      if (o == op_addi || o == op_addf || o == op_addc)
      begin
         r = sum[7:0];
         {m_c, m_dc} = {sum[8], h[4]};
      end
      if (o == op_asr)
         m_c = f[0];
      if (o == op_ptr && d)
         m_p1 = m_p1 + {{10{l[5]}}, l};
      else if (o == op_ptr)
         m_p0 = m_p0 + {{10{l[5]}}, l};
      wr = d && o != op_addi && o != op_andi && o != op_ptr && o != op_none;
      if (o != op_ptr && o != op_none)
         m_z = (r == 8'h00);
      if (o != op_ptr && o != op_none && !wr)
         m_acc = r;
      @(posedge ref_clk);
      #1;
      chk({8'h00, acc}, {8'h00, m_acc});
      chk(indirect_pointer0, m_p0);
      chk(indirect_pointer1, m_p1);
      chk({13'h0000, carry_flag, half_carry_flag, zero_flag},
         {13'h0000, m_c, m_dc, m_z});
      chk({15'h0000, file_we}, {15'h0000, wr});
      if (wr) chk({8'h00, file_wdata}, {8'h00, r});
   endtask
   // Sums, half carry, zero and routing; dest ignored for immediates
   task automatic t_add;
      step(op_none, 8'h00, 8'h00, 1'b0, 6'h00);
      step(op_addi, 8'h0f, 8'h00, 1'b1, 6'h00);
      step(op_addi, 8'h01, 8'h00, 1'b0, 6'h00);
      step(op_addi, 8'hf0, 8'h00, 1'b0, 6'h00);
      step(op_addf, 8'h00, 8'h7f, 1'b1, 6'h00);
      step(op_addf, 8'h00, 8'h80, 1'b0, 6'h00);
   endtask
   // Carry in taken from the flag left by the previous op, back to back
   task automatic t_addc;
      step(op_addi, 8'h80, 8'h00, 1'b0, 6'h00);
      step(op_addc, 8'h00, 8'h0f, 1'b0, 6'h00);
      step(op_addc, 8'h00, 8'hff, 1'b1, 6'h00);
      step(op_addc, 8'h00, 8'hff, 1'b0, 6'h00);
   endtask
   // Logic ops touch only the zero flag; C and DC enter set
   task automatic t_and;
      step(op_andi, 8'h11, 8'h00, 1'b1, 6'h00);
      step(op_andf, 8'h00, 8'hff, 1'b1, 6'h00);
      step(op_andf, 8'h00, 8'h02, 1'b0, 6'h00);
   endtask
   // Sign kept, low bit to carry, half carry left alone
   task automatic t_asr;
      step(op_asr, 8'h00, 8'h81, 1'b1, 6'h00);
      step(op_asr, 8'h00, 8'h02, 1'b0, 6'h00);
      step(op_asr, 8'h00, 8'h01, 1'b0, 6'h00);
   endtask
   // Literal extremes and wrap both ways, flags untouched
   task automatic t_ptr;
      step(op_ptr, 8'h00, 8'h00, 1'b0, 6'h1f);
      step(op_ptr, 8'h00, 8'h00, 1'b1, 6'h20);
      step(op_ptr, 8'h00, 8'h00, 1'b0, 6'h20);
      step(op_ptr, 8'h00, 8'h00, 1'b0, 6'h01);
   endtask
   // Cut a hung run short
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 1000)
      begin
         n_errors++;
         tally_and_finish;
      end
   end
   // Main sequence
   initial
   begin
      repeat (12) @(posedge ref_clk);
      #1;
      resetn = 1'b1;
      t_add;
      t_addc;
      t_and;
      t_asr;
      t_ptr;
      tally_and_finish;
   end
endmodule
